// [src/blsc_pkg.sv]
package blsc_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] OPC_REGION_LOCK = 8'h36;
  localparam logic [7:0] OPC_REGION_UNLOCK = 8'h39;
  localparam logic [7:0] OPC_REGION_LOCK_READ = 8'h3c;
  localparam logic [7:0] OPC_WHOLE_CHIP_LOCK = 8'h7e;
  localparam logic [7:0] OPC_WHOLE_CHIP_UNLOCK = 8'h98;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_RESUME_A = 8'h7a;
  localparam logic [7:0] OPC_RESUME_B = 8'h30;
  localparam logic [7:0] OPC_RESET_ARM = 8'h66;
  localparam logic [7:0] OPC_RESET = 8'h99;
  localparam logic [7:0] OPC_NO_OPERATION = 8'h00;
  localparam logic [7:0] OPC_SUSPEND = 8'hb0;

  // ****************************************************************
  // Frame layout and lock regions
  // ****************************************************************
  localparam int ADDR_W = 24;
  localparam logic [2:0] BYTES_BARE = 3'h1;
  localparam logic [2:0] BYTES_ADDRESSED = 3'h4;
  localparam logic [2:0] BYTES_MAX = 3'h7;
  localparam logic [3:0] BITS_SPI = 4'h1;
  localparam logic [3:0] BITS_QUAD = 4'h4;
  localparam logic [3:0] OE_SPI = 4'h2;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam int REGION_CNT = 32;
  localparam int REGION_W = 5;
  localparam logic [REGION_CNT-1:0] LOCK_RESET = 32'hffffffff;
  localparam logic [1:0] KIND_PAGE = 2'h0;
  localparam logic [1:0] KIND_SECTOR = 2'h1;
  localparam logic [1:0] KIND_HALF_BLOCK = 2'h2;
  localparam logic [1:0] KIND_BLOCK = 2'h3;

  // ****************************************************************
  // Suspend timing and status
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROGRAM_SUSPEND_LATENCY_NS = 20000;
  localparam int ERASE_SUSPEND_LATENCY_NS = 20000;
  localparam int LAT_W = 12;
  localparam logic [LAT_W-1:0] PROGRAM_SUSPEND_CYCLES =
    LAT_W'((PROGRAM_SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [LAT_W-1:0] ERASE_SUSPEND_CYCLES =
    LAT_W'((ERASE_SUSPEND_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SUSP_PROGRAM_BIT = 2;
  localparam int SUSP_ERASE_BIT = 3;

  typedef enum logic [2:0] {
    SUS_IDLE = 3'b001,
    SUS_WAIT = 3'b010,
    SUS_HELD = 3'b100
  } blsc_susp_t;

  // Block 0 is split into 4 KB sectors; other 64 KB blocks share 16 regions chosen by address bits 19:16.
  function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
    if (a[23:16] == 8'h00) begin
      region_of = {1'b0, a[15:12]};
    end else begin
      region_of = {1'b1, a[19:16]};
    end
  endfunction

endpackage

// [src/blsc_lock_if.sv]
`timescale 1ns/1ps
interface blsc_lock_if;
  logic wr_en;
  logic [blsc_pkg::REGION_W-1:0] wr_idx;
  logic wr_val;
  logic set_all;
  logic clr_all;
  logic [blsc_pkg::REGION_W-1:0] q_idx;
  logic q_val;
  logic [blsc_pkg::REGION_W-1:0] chk_idx;
  logic chk_val;

  modport core (
    output wr_en, wr_idx, wr_val, set_all, clr_all, q_idx, chk_idx,
    input q_val, chk_val
  );
  modport mem (
    input wr_en, wr_idx, wr_val, set_all, clr_all, q_idx, chk_idx,
    output q_val, chk_val
  );
endinterface

// [src/blsc_lock_mem.sv]
`timescale 1ns/1ps
module blsc_lock_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  blsc_lock_if.mem lk
);

  logic [blsc_pkg::REGION_CNT-1:0] bits_q;

  // ****************************************************************
  // Lock bit storage
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_q <= blsc_pkg::LOCK_RESET;
    end else if (ce) begin
      if (lk.set_all) begin
        bits_q <= blsc_pkg::LOCK_RESET;
      end else if (lk.clr_all) begin
        bits_q <= '0;
      end else if (lk.wr_en) begin
        bits_q[lk.wr_idx] <= lk.wr_val;
      end
    end
  end

  // ****************************************************************
  // Registered read ports
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lk.q_val <= 1'b1;
      lk.chk_val <= 1'b1;
    end else if (ce) begin
      lk.q_val <= bits_q[lk.q_idx];
      lk.chk_val <= bits_q[lk.chk_idx];
    end
  end

endmodule // blsc_lock_mem

// [src/blsc_link.sv]
`timescale 1ns/1ps
module blsc_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic [3:0] sio_i,
  input wire logic out_lvl,
  input wire logic [3:0] out_en,
  output logic edge_tgl,
  output logic [3:0] edge_bits,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe
);

  logic lvl_s1;
  logic lvl_s2;
  logic [3:0] en_s1;
  logic [3:0] en_s2;

  // ****************************************************************
  // Capture
  // ****************************************************************
  // Every rising edge is handed over whole; the core assembles bytes. This
  // needs a serial clock edge spacing of at least five core cycles.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_tgl <= 1'b0;
      edge_bits <= 4'h0;
    end else begin
      edge_tgl <= ~edge_tgl;
      edge_bits <= sio_i;
    end
  end

  // ****************************************************************
  // Drive
  // ****************************************************************
  // Chip select high releases the lines at once, since no edge follows.
  always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      lvl_s1 <= 1'b0;
      lvl_s2 <= 1'b0;
      en_s1 <= 4'h0;
      en_s2 <= 4'h0;
      sio_o <= 4'h0;
      sio_oe <= 4'h0;
    end else if (cs_n) begin
      lvl_s1 <= 1'b0;
      lvl_s2 <= 1'b0;
      en_s1 <= 4'h0;
      en_s2 <= 4'h0;
      sio_o <= 4'h0;
      sio_oe <= 4'h0;
    end else begin
      lvl_s1 <= out_lvl;
      lvl_s2 <= lvl_s1;
      en_s1 <= out_en;
      en_s2 <= en_s1;
      sio_o <= {4{lvl_s2}};
      sio_oe <= en_s2;
    end
  end

endmodule // blsc_link

// [src/blsc_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Lock commands act only while protection mode select is one.
// - Opcode 36h sets the addressed block or sector lock bit.
// - Opcode 39h clears the addressed block or sector lock bit.
// - Single lock or unlock needs opcode, three address bytes, byte-aligned deselect.
// - Whole-chip lock or unlock is discarded unless deselect is byte aligned.
// - Opcodes arrive as eight single-line or two four-line clocks.
// - Lock status read returns addressed lock bit after three address bytes.
// - Status one means read only; zero means readable and writable.
// - 7Eh locks and 98h unlocks all blocks; bare opcode, write enable.
// - Suspend interrupts a running page program or erase.
// - While suspended, reads are blocked only in the busy page or area.
// - After suspend latency, clear write enable latch and set suspend flag.
// - After the latency, listed reads, write enable, resume and others pass.
// - Status reads, write disable, reset commands and no-op pass anytime.
// - Program suspend shows in bit 2, erase suspend in bit 3.
// - Resume sets write enable latch and busy, clears suspend flag.
// - Resume is ignored in performance enhance mode.
// - No-operation only cancels a pending reset arm.
// - All lock bits come up set after reset.
// - Write-protect pin low refuses writes everywhere in individual mode.
module blsc_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic [3:0] SIO_I,
  output logic [3:0] SIO_O,
  output logic [3:0] SIO_OE,
  input wire logic QUAD_COMMAND_MODE,
  input wire logic PROTECTION_MODE_SELECT,
  input wire logic WP_N,
  input wire logic PERF_MODE,
  input wire logic ENGINE_BUSY,
  input wire logic ENGINE_ERASE,
  input wire logic [23:0] OP_ADDR,
  input wire logic [1:0] OP_KIND,
  input wire logic [23:0] CHECK_ADDR,
  input wire logic [23:0] READ_ADDR,
  output logic WRITE_ENABLE_LATCH,
  output logic WRITE_IN_PROGRESS,
  output logic [7:0] SUSPEND_FLAGS,
  output logic ENGINE_HOLD,
  output logic SOFT_RESET,
  output logic CMD_STROBE,
  output logic [7:0] CMD_CODE,
  output logic WRITE_BLOCKED,
  output logic READ_BLOCKED
);

  // ****************************************************************
  // Command filters while suspended
  // ****************************************************************
  function automatic logic ok_anytime(input logic [7:0] op);
    case (op)
      8'h04, 8'h05, 8'h15, 8'h2b, 8'hab, 8'h66, 8'h99, 8'h00: ok_anytime = 1'b1;
      default: ok_anytime = 1'b0;
    endcase
  endfunction

  function automatic logic ok_after_latency(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'he7, 8'h5a, 8'h9f, 8'haf, 8'h90,
      8'hb1, 8'hc1, 8'h06, 8'h35, 8'hf5, 8'h7a, 8'h30, 8'hc0: ok_after_latency = 1'b1;
      default: ok_after_latency = 1'b0;
    endcase
  endfunction

  blsc_lock_if lk ();

  logic link_tgl, out_lvl_q, cs_s1, cs_s2, cs_s3, wp_s1, wp_s2, tgl_s1, tgl_s2, tgl_s3;
  logic [3:0] link_bits, out_en_q, bits_s1, bits_s2, bit_sum;
  logic frame_end_q, status_go_q, erase_q, arm_q, edge_seen, byte_done, aligned;
  logic cmd_ok, bare, exec_lock, exec_gang, exec_suspend, exec_resume, exec_reset, area_hit;
  logic [2:0] bit_cnt_q, byte_cnt_q;
  logic [7:0] shift_q, opcode_q, byte_next;
  logic [23:0] addr_q, op_addr_q;
  logic [1:0] kind_q;
  logic [blsc_pkg::LAT_W-1:0] lat_q;
  blsc_pkg::blsc_susp_t susp_q;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  blsc_link u_link (
    .sclk(SCLK),
    .cs_n(CS_N),
    .rst_n(RSTN),
    .sio_i(SIO_I),
    .out_lvl(out_lvl_q),
    .out_en(out_en_q),
    .edge_tgl(link_tgl),
    .edge_bits(link_bits),
    .sio_o(SIO_O),
    .sio_oe(SIO_OE)
  );

  blsc_lock_mem u_mem (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .lk(lk)
  );

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
      bits_s1 <= 4'h0;
      bits_s2 <= 4'h0;
      frame_end_q <= 1'b0;
    end else if (CE) begin
      cs_s1 <= CS_N;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= WP_N;
      wp_s2 <= wp_s1;
      tgl_s1 <= link_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
      bits_s1 <= link_bits;
      bits_s2 <= bits_s1;
      // One cycle late; a last edge arriving with the deselect is not counted, since edge_seen needs chip select low.
      frame_end_q <= cs_s2 & ~cs_s3;
    end
  end

  // ****************************************************************
  // Byte assembly
  // ****************************************************************
  always_comb begin
    edge_seen = (tgl_s2 != tgl_s3) && !cs_s2;
    bit_sum = {1'b0, bit_cnt_q} +
              (QUAD_COMMAND_MODE ? blsc_pkg::BITS_QUAD : blsc_pkg::BITS_SPI);
    byte_next = QUAD_COMMAND_MODE ? {shift_q[3:0], bits_s2} :
                                    {shift_q[6:0], bits_s2[0]};
    byte_done = edge_seen && bit_sum[3];
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (CE) begin
      if (cs_s2 && !cs_s3) begin
        bit_cnt_q <= bit_cnt_q;
      end else if (!cs_s2 && cs_s3) begin
        bit_cnt_q <= 3'h0;
        byte_cnt_q <= 3'h0;
      end else if (edge_seen) begin
        bit_cnt_q <= bit_sum[2:0];
        shift_q <= byte_next;
        if (byte_done) begin
          if (byte_cnt_q != blsc_pkg::BYTES_MAX) begin
            byte_cnt_q <= byte_cnt_q + 3'h1;
          end
          if (byte_cnt_q == 3'h0) begin
            opcode_q <= byte_next;
          end else if (byte_cnt_q < blsc_pkg::BYTES_ADDRESSED) begin
            addr_q <= {addr_q[15:0], byte_next};
          end
        end
      end
    end
  end

  // ****************************************************************
  // Frame-end decode
  // ****************************************************************
  always_comb begin
    aligned = (bit_cnt_q == 3'h0);
    cmd_ok = (susp_q == blsc_pkg::SUS_IDLE) || ok_anytime(opcode_q) ||
             ((susp_q == blsc_pkg::SUS_HELD) && ok_after_latency(opcode_q));
    bare = frame_end_q && aligned && cmd_ok && (byte_cnt_q == blsc_pkg::BYTES_BARE);
    exec_lock = frame_end_q && aligned && cmd_ok && PROTECTION_MODE_SELECT &&
                WRITE_ENABLE_LATCH &&
                (byte_cnt_q == blsc_pkg::BYTES_ADDRESSED) &&
                ((opcode_q == blsc_pkg::OPC_REGION_LOCK) ||
                 (opcode_q == blsc_pkg::OPC_REGION_UNLOCK));
    exec_gang = bare && PROTECTION_MODE_SELECT && WRITE_ENABLE_LATCH &&
                ((opcode_q == blsc_pkg::OPC_WHOLE_CHIP_LOCK) ||
                 (opcode_q == blsc_pkg::OPC_WHOLE_CHIP_UNLOCK));
    exec_suspend = bare && (opcode_q == blsc_pkg::OPC_SUSPEND) && ENGINE_BUSY &&
                   (susp_q == blsc_pkg::SUS_IDLE);
    exec_resume = bare && (susp_q == blsc_pkg::SUS_HELD) && !PERF_MODE &&
                  ((opcode_q == blsc_pkg::OPC_RESUME_A) || (opcode_q == blsc_pkg::OPC_RESUME_B));
    exec_reset = bare && arm_q && (opcode_q == blsc_pkg::OPC_RESET);
  end

  // ****************************************************************
  // Lock bit access
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lk.wr_en <= 1'b0;
      lk.wr_idx <= '0;
      lk.wr_val <= 1'b0;
      lk.set_all <= 1'b0;
      lk.clr_all <= 1'b0;
    end else if (CE) begin
      lk.wr_en <= exec_lock;
      lk.wr_idx <= blsc_pkg::region_of(addr_q);
      lk.wr_val <= (opcode_q == blsc_pkg::OPC_REGION_LOCK);
      lk.set_all <= (exec_gang && (opcode_q == blsc_pkg::OPC_WHOLE_CHIP_LOCK)) ||
                    exec_reset;
      lk.clr_all <= exec_gang && (opcode_q == blsc_pkg::OPC_WHOLE_CHIP_UNLOCK);
    end
  end

  assign lk.q_idx = blsc_pkg::region_of(addr_q);
  assign lk.chk_idx = blsc_pkg::region_of(CHECK_ADDR);

  // ****************************************************************
  // Lock status read-out
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      status_go_q <= 1'b0;
      out_en_q <= 4'h0;
      out_lvl_q <= 1'b0;
    end else if (CE) begin
      status_go_q <= byte_done && (byte_cnt_q == blsc_pkg::BYTES_ADDRESSED - 3'h1) && cmd_ok &&
                     PROTECTION_MODE_SELECT &&
                     (opcode_q == blsc_pkg::OPC_REGION_LOCK_READ);
      out_lvl_q <= lk.q_val;
      if (cs_s2) begin
        out_en_q <= 4'h0;
      end else if (status_go_q) begin
        out_en_q <= QUAD_COMMAND_MODE ? blsc_pkg::OE_QUAD : blsc_pkg::OE_SPI;
      end
    end
  end

  // ****************************************************************
  // Suspend state
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      susp_q <= blsc_pkg::SUS_IDLE;
      lat_q <= '0;
      erase_q <= 1'b0;
      kind_q <= blsc_pkg::KIND_PAGE;
      op_addr_q <= 24'h000000;
      ENGINE_HOLD <= 1'b0;
      SUSPEND_FLAGS <= 8'h00;
    end else if (CE) begin
      case (susp_q)
        blsc_pkg::SUS_IDLE: begin
          if (exec_suspend) begin
            susp_q <= blsc_pkg::SUS_WAIT;
            erase_q <= ENGINE_ERASE;
            kind_q <= OP_KIND;
            op_addr_q <= OP_ADDR;
            ENGINE_HOLD <= 1'b1;
            lat_q <= ENGINE_ERASE ? blsc_pkg::ERASE_SUSPEND_CYCLES :
                                    blsc_pkg::PROGRAM_SUSPEND_CYCLES;
          end
        end
        blsc_pkg::SUS_WAIT: begin
          if (exec_reset) begin
            susp_q <= blsc_pkg::SUS_IDLE;
            ENGINE_HOLD <= 1'b0;
          end else if (lat_q <= 1) begin
            susp_q <= blsc_pkg::SUS_HELD;
            SUSPEND_FLAGS[blsc_pkg::SUSP_ERASE_BIT] <= erase_q;
            SUSPEND_FLAGS[blsc_pkg::SUSP_PROGRAM_BIT] <= ~erase_q;
          end else begin
            lat_q <= lat_q - 1'b1;
          end
        end
        blsc_pkg::SUS_HELD: begin
          if (exec_resume || exec_reset) begin
            susp_q <= blsc_pkg::SUS_IDLE;
            ENGINE_HOLD <= 1'b0;
            SUSPEND_FLAGS <= 8'h00;
          end
        end
        default: begin
          susp_q <= blsc_pkg::SUS_IDLE;
          ENGINE_HOLD <= 1'b0;
          SUSPEND_FLAGS <= 8'h00;
        end
      endcase
    end
  end

  // ****************************************************************
  // Latches, reset arming and forwarding
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WRITE_ENABLE_LATCH <= 1'b0;
      WRITE_IN_PROGRESS <= 1'b0;
      arm_q <= 1'b0;
      SOFT_RESET <= 1'b0;
      CMD_STROBE <= 1'b0;
      CMD_CODE <= 8'h00;
    end else if (CE) begin
      SOFT_RESET <= exec_reset;
      CMD_STROBE <= bare;
      if (bare) begin
        CMD_CODE <= opcode_q;
        // Any accepted single-byte command other than 66h, the no-operation code included, drops a pending arm.
        arm_q <= (opcode_q == blsc_pkg::OPC_RESET_ARM);
      end
      WRITE_IN_PROGRESS <= exec_resume ||
                           (ENGINE_BUSY && (susp_q == blsc_pkg::SUS_IDLE));
      if (exec_reset) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end else if (exec_resume) begin
        WRITE_ENABLE_LATCH <= 1'b1;
      end else if ((susp_q == blsc_pkg::SUS_WAIT) && (lat_q <= 1)) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end else if (exec_lock || exec_gang) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end else if (bare && (opcode_q == blsc_pkg::OPC_WRITE_ENABLE)) begin
        WRITE_ENABLE_LATCH <= 1'b1;
      end else if (bare && (opcode_q == blsc_pkg::OPC_WRITE_DISABLE)) begin
        WRITE_ENABLE_LATCH <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Protection checks for the array engine
  // ****************************************************************
  always_comb begin
    case (kind_q)
      blsc_pkg::KIND_PAGE: area_hit = (READ_ADDR[23:8] == op_addr_q[23:8]);
      blsc_pkg::KIND_SECTOR: area_hit = (READ_ADDR[23:12] == op_addr_q[23:12]);
      blsc_pkg::KIND_HALF_BLOCK: area_hit = (READ_ADDR[23:15] == op_addr_q[23:15]);
      default: area_hit = (READ_ADDR[23:16] == op_addr_q[23:16]);
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      READ_BLOCKED <= 1'b0;
      WRITE_BLOCKED <= 1'b0;
    end else if (CE) begin
      READ_BLOCKED <= (susp_q != blsc_pkg::SUS_IDLE) && area_hit;
      // The check address is looked up one cycle earlier in the lock memory.
      WRITE_BLOCKED <= PROTECTION_MODE_SELECT && (!wp_s2 || lk.chk_val);
    end
  end

endmodule // blsc_top

// [bench/blsc_properties.sv]
`timescale 1ns/1ps
// ********************
// Port checks of the lock and suspend block.
// ********************
module blsc_properties (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic CS_N,
  input wire logic QUAD_COMMAND_MODE,
  input wire logic PROTECTION_MODE_SELECT,
  input wire logic WP_N,
  input wire logic [3:0] SIO_OE,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic WRITE_IN_PROGRESS,
  input wire logic [7:0] SUSPEND_FLAGS,
  input wire logic ENGINE_HOLD,
  input wire logic SOFT_RESET,
  input wire logic CMD_STROBE,
  input wire logic WRITE_BLOCKED,
  input wire logic READ_BLOCKED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || !CE);
  property p_flag_bits; SUSPEND_FLAGS[7:4] == 4'h0 && SUSPEND_FLAGS[1:0] == 2'h0; endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("stray suspend flag");
  property p_susp_wel; $rose(|SUSPEND_FLAGS) |-> !WRITE_ENABLE_LATCH; endproperty
  a_susp_wel: assert property (p_susp_wel) else $error("latch set at suspend");
  property p_susp_lat; $rose(ENGINE_HOLD) |-> (SUSPEND_FLAGS == 8'h00) [*8]; endproperty
  a_susp_lat: assert property (p_susp_lat) else $error("suspend flag too early");
  property p_hold; |SUSPEND_FLAGS |-> ENGINE_HOLD; endproperty
  a_hold: assert property (p_hold) else $error("suspended without hold");
  property p_resume;
    $fell(|SUSPEND_FLAGS) && !SOFT_RESET && !$past(SOFT_RESET) |->
      WRITE_ENABLE_LATCH && WRITE_IN_PROGRESS;
  endproperty
  a_resume: assert property (p_resume) else $error("resume left latch or busy low");
  property p_rdblk; READ_BLOCKED |-> ENGINE_HOLD || $past(ENGINE_HOLD); endproperty
  a_rdblk: assert property (p_rdblk) else $error("read blocked while running");
  property p_pms_off; !PROTECTION_MODE_SELECT [*3] |-> !WRITE_BLOCKED; endproperty
  a_pms_off: assert property (p_pms_off) else $error("write blocked in other mode");
  property p_wp; (PROTECTION_MODE_SELECT && !WP_N) [*4] |-> WRITE_BLOCKED; endproperty
  a_wp: assert property (p_wp) else $error("protect pin ignored");
  property p_oe;
    SIO_OE != 4'h0 |-> !CS_N && SIO_OE == (QUAD_COMMAND_MODE ? 4'hf : 4'h2);
  endproperty
  a_oe: assert property (p_oe) else $error("bad output enable");
  property p_strobe; CMD_STROBE |-> $past(CS_N, 3); endproperty
  a_strobe: assert property (p_strobe) else $error("command inside frame");
endmodule // blsc_properties

// [bench/blsc_host.sv]
`timescale 1ns/1ps
// ********************
// Host controller on the serial link.
// ********************
module blsc_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] sio_i,
  input wire logic quad,
  input wire logic [3:0] sio_o,
  input wire logic [3:0] sio_oe
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sio_i = 4'ha;
  end
  // The clock stands still between frames, so released lines show the inverse level.
  task automatic frame(input logic [31:0] d, input int n, input int x, output logic st);
    st = 1'bx;
    cs_n = 1'b0;
    for (int i = 0; i < n + x; i++) begin
      sio_i = quad ? d[31:28] : {~sio_i[3:1], d[31]};
      d = quad ? d << 4 : d << 1;
      #40 sclk = 1'b1;
      if (sio_oe != 4'h0) st = sio_o[1];
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    sio_i = ~sio_i;
  endtask
endmodule // blsc_host

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic quad; logic pms; logic write_enable_cmd; logic [7:0] op; logic [23:0] a; logic st; logic write_enable_latch;
  } blsc_row_t;
  logic clk, rst_n, ce, pms, wp_n, perf, busy, erase, quad, sclk, cs_n, st;
  logic write_enable_latch, write_in_progress, hold, srst, stb, wblk, rblk;
  logic [23:0] op_addr, check_addr, read_addr;
  logic [1:0] op_kind;
  logic [3:0] sio_i, sio_o, sio_oe;
  logic [7:0] flags, code;
  int miscompares, comparisons, b;
  blsc_row_t rows [7] = '{
    '{1'b0, 1'b1, 1'b1, 8'h39, 24'h050000, 1'b0, 1'b0},
    '{1'b1, 1'b1, 1'b1, 8'h36, 24'h050000, 1'b1, 1'b0},
    '{1'b0, 1'b1, 1'b0, 8'h39, 24'h050000, 1'b1, 1'b0},
    '{1'b0, 1'b0, 1'b1, 8'h39, 24'h050000, 1'b1, 1'b1},
    '{1'b0, 1'b1, 1'b1, 8'h98, 24'h003000, 1'b0, 1'b0},
    '{1'b1, 1'b1, 1'b1, 8'h36, 24'h003000, 1'b1, 1'b0},
    '{1'b0, 1'b1, 1'b1, 8'h7e, 24'h0a0000, 1'b1, 1'b0}};
  blsc_host host_u (.sclk(sclk), .cs_n(cs_n), .sio_i(sio_i), .quad(quad), .sio_o(sio_o),
    .sio_oe(sio_oe));
  blsc_top dut_u (.REF_CLK(clk), .RSTN(rst_n), .CE(ce), .SCLK(sclk), .CS_N(cs_n),
    .SIO_I(sio_i), .SIO_O(sio_o), .SIO_OE(sio_oe), .QUAD_COMMAND_MODE(quad),
    .PROTECTION_MODE_SELECT(pms), .WP_N(wp_n), .PERF_MODE(perf), .ENGINE_BUSY(busy),
    .ENGINE_ERASE(erase), .OP_ADDR(op_addr), .OP_KIND(op_kind), .CHECK_ADDR(check_addr),
    .READ_ADDR(read_addr), .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS(write_in_progress),
    .SUSPEND_FLAGS(flags), .ENGINE_HOLD(hold), .SOFT_RESET(srst), .CMD_STROBE(stb),
    .CMD_CODE(code), .WRITE_BLOCKED(wblk), .READ_BLOCKED(rblk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(input logic [31:0] d, input int n);
    host_u.frame(d, n, 0, st);
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [23:0] a, input logic e);
    check_addr = a;
    host_u.frame({8'h3c, a}, 4 * b, 16, st);
    repeat (10) @(posedge clk);
    #1;
    chk("lock status", {7'h00, e}, {7'h00, st});
    chk("write blocked", {7'h00, e}, {7'h00, wblk});
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {rst_n, perf, busy, erase, quad, op_kind} = '0;
    {pms, wp_n, ce} = 3'b111;
    {op_addr, check_addr, read_addr} = '0;
    b = 8;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rd(24'h0a0000, 1'b1);
    foreach (rows[i]) begin
      quad = rows[i].quad;
      b = quad ? 2 : 8;
      pms = rows[i].pms;
      if (rows[i].write_enable_cmd) cmd(32'h06000000, b);
      cmd({rows[i].op, rows[i].a}, (rows[i].op inside {8'h7e, 8'h98}) ? b : 4 * b);
      pms = 1'b1;
      chk("latch", {7'h00, rows[i].write_enable_latch}, {7'h00, write_enable_latch});
      rd(rows[i].a, rows[i].st);
    end
    cmd(32'h06000000, 8);
    cmd(32'h98000000, 8);
    cmd(32'h06000000, 8);
    cmd(32'h36050000, 28);
    rd(24'h050000, 1'b0);
    cmd(32'h06000000, 8);
    cmd(32'h7e000000, 12);
    rd(24'h0a0000, 1'b0);
    ce = 1'b0;
    wp_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("frozen write blocked", 8'h00, {7'h00, wblk});
    ce = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("write blocked", 8'h01, {7'h00, wblk});
    wp_n = 1'b1;
    cmd(32'h66000000, 8);
    cmd(32'h00000000, 8);
    chk("code", 8'h00, code);
    cmd(32'h99000000, 8);
    rd(24'h050000, 1'b0);
    cmd(32'h66000000, 8);
    cmd(32'h99000000, 8);
    rd(24'h050000, 1'b1);
    for (int k = 0; k < 2; k++) begin
      {busy, erase, op_kind, op_addr, read_addr} = {1'b1, k[0], {2{k[0]}}, 24'h050000, 24'h050010};
      cmd(32'h06000000, 8);
      cmd(32'hb0000000, 8);
      chk("hold", 8'h01, {7'h00, hold});
      chk("read blocked", 8'h01, {7'h00, rblk});
      read_addr = 24'h060000;
      #8 chk("read blocked", 8'h00, {7'h00, rblk});
      repeat (2600) @(posedge clk);
      #1 chk("flags", k ? 8'h08 : 8'h04, flags);
      chk("latch", 8'h00, {7'h00, write_enable_latch});
      perf = 1'b1;
      cmd(32'h7a000000, 8);
      chk("flags", k ? 8'h08 : 8'h04, flags);
      perf = 1'b0;
      cmd({k ? 8'h30 : 8'h7a, 24'h000000}, 8);
      chk("flags", 8'h00, flags);
      chk("latch busy", 8'h03, {6'h00, write_enable_latch, write_in_progress});
      busy = 1'b0;
    end
    results();
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule // tb
bind blsc_top blsc_properties chk_u (.REF_CLK, .RSTN, .CE, .CS_N, .QUAD_COMMAND_MODE,
  .PROTECTION_MODE_SELECT, .WP_N, .SIO_OE, .WRITE_ENABLE_LATCH, .WRITE_IN_PROGRESS,
  .SUSPEND_FLAGS, .ENGINE_HOLD, .SOFT_RESET, .CMD_STROBE, .WRITE_BLOCKED, .READ_BLOCKED);
